// ---- rtl/bic_top.sv ----
// Function
// - Drive host modifier byte on structure writes
// - Structure starts at host supplied address
// - Command code 15H means board information
// - Format bit picks eight or sixteen targets
// - General header comes before target data
// - Target blocks ascend from identifier zero
// - Sense count, retry, time-out at 14H
// - Single or listed command, normal status
`timescale 1ns/1ps
`include "bic_consts.svh"

module bic_top (
    input  wire logic                  mclk_i,         // Clock, 20 MHz
    input  wire logic                  rst_i,          // Sync reset, high
    input  wire logic                  start_i,        // Fetch a parameter block
    input  wire logic [31:0]           pb_addr_i,      // Parameter block address
    input  wire logic [7:0]            pb_am_i,        // Modifier for block fetch
    input  wire logic                  mem_ack_i,      // Memory transfer done
    input  wire logic [31:0]           mem_rdata_i,    // Memory read data
    input  wire logic [7:0]            fw_rel_i,       // Firmware release level
    input  wire logic [7:0]            eng_rev_i,      // Engineering revision
    input  wire logic [7:0]            throttle_i,     // Bus throttle
    input  wire logic [7:0]            sel_flags_i,    // Select flags
    input  wire logic [7:0]            opt_flags_i,    // Option flags
    input  wire logic [7:0]            day_i,          // Build day
    input  wire logic [7:0]            month_i,        // Build month
    input  wire logic [7:0]            year_i,         // Build year
    input  wire logic [31:0]           even_fw_i,      // Even EPROM number
    input  wire logic [7:0]            cfig_pin_i,     // Jumper block pins
    input  wire logic [7:0]            term_pin_i,     // Termination pins
    input  wire bic_pkg::bic_byte16_t  sense_cnt_i,    // Sense count per target
    input  wire bic_pkg::bic_byte16_t  retry_i,        // Retry limit per target
    input  wire bic_pkg::bic_half16_t  disc_to_i,      // Disconnect time-out
    input  wire bic_pkg::bic_byte16_t  sync_off_i,     // Synch offset
    input  wire bic_pkg::bic_byte16_t  sync_per_i,     // Synch period
    input  wire bic_pkg::bic_half16_t  dev_flags_i,    // Device flags
    input  wire bic_pkg::bic_byte16_t  width_i,        // Transfer width
    input  wire bic_pkg::bic_sense16_t sense_i,        // Sense bytes
    output logic                       mem_req_o,      // Memory request
    output logic                       mem_we_o,       // Write when high
    output logic [31:0]                mem_addr_o,     // Memory byte address
    output logic [31:0]                mem_wdata_o,    // Memory write data
    output logic [7:0]                 mem_am_o,       // Address modifier
    output logic                       busy_o,         // Command in progress
    output logic                       status_valid_o, // Status block pulse
    output logic [31:0]                status_id_o,    // Command identifier
    output logic [7:0]                 status_code_o   // Completion code
);
    // Word address step
    function automatic logic [31:0] next_addr(input logic [31:0] a);
        next_addr = a + `BIC_WSTEP;
    endfunction

    bic_pkg::bic_state_e st_r;                 // Sequencer state
    logic [31:0]         pw_r [0:4];           // Fetched parameter words
    logic [2:0]          rd_cnt_r;             // Fetch word counter
    logic [6:0]          wi_r;                 // Structure word counter
    logic [3:0]          tgt_r;                // Current target identifier
    logic [2:0]          wrd_r;                // Word within target block
    logic [7:0]          code_r;               // Pending completion code
    logic                req_r;                // Request flop
    logic                we_r;                 // Write flop
    logic [31:0]         addr_r;               // Address flop
    logic [31:0]         wdata_r;              // Write data flop
    logic [7:0]          am_r;                 // Modifier flop
    logic                busy_r;               // Busy flop
    logic                stv_r;                // Status valid flop
    logic [31:0]         sid_r;                // Status identifier flop
    logic [7:0]          scode_r;              // Status code flop
    logic [7:0]          cf_s1_r, cf_s2_r, cf_s3_r, cf_q_r;   // Jumper sync chain
    logic [7:0]          tm_s1_r, tm_s2_r, tm_s3_r, tm_q_r;   // Termination sync chain
    logic [31:0]         gen_w;                // Next structure word

    // Parameter block decode
    wire id_ok   = (pw_r[`BIC_PW_AM][7:0] == `BIC_ADP_ID);
    wire code_ok = (pw_r[`BIC_PW_CMD][31:24] == `BIC_CMD_INFO);
    wire cmd_ok  = id_ok & code_ok;
    wire id_count_format_bit = pw_r[`BIC_PW_CMD][`BIC_ID_COUNT_FORMAT_POS];
    wire [6:0] last_w = id_count_format_bit ? `BIC_LAST16 : `BIC_LAST8;
    wire rd_last = (rd_cnt_r == `BIC_PB_LAST);
    wire is_chk  = (st_r == bic_pkg::BIC_CHECK);

    // Walk position: header first, then targets in ascending order
    wire       in_hdr = (wi_r <= `BIC_HDR_LAST);
    wire       tw_end = (wrd_r == `BIC_TW_LAST);
    wire [6:0] n_wi   = wi_r + 7'h01;
    wire [3:0] n_tgt  = in_hdr ? 4'h0 : (tw_end ? tgt_r + 4'h1 : tgt_r);
    wire [2:0] n_wrd  = (in_hdr | tw_end) ? 3'h0 : wrd_r + 3'h1;
    // Generator position: start of structure while checking
    wire [6:0] g_wi   = is_chk ? 7'h00 : n_wi;
    wire [3:0] g_tgt  = is_chk ? 4'h0 : n_tgt;
    wire [2:0] g_wrd  = is_chk ? 3'h0 : n_wrd;
    wire       g_hdr  = (g_wi <= `BIC_HDR_LAST);

    // Structure word assembly
    bic_word_gen u_gen (
        .hdr_i       (g_hdr),
        .hw_i        (g_wi[2:0]),
        .tgt_i       (g_tgt),
        .tw_i        (g_wrd),
        .fw_rel_i    (fw_rel_i),
        .eng_rev_i   (eng_rev_i),
        .throttle_i  (throttle_i),
        .sel_flags_i (sel_flags_i),
        .opt_flags_i (opt_flags_i),
        .day_i       (day_i),
        .month_i     (month_i),
        .year_i      (year_i),
        .even_fw_i   (even_fw_i),
        .cfig_i      (cf_q_r),
        .term_i      (tm_q_r),
        .sense_cnt_i (sense_cnt_i),
        .retry_i     (retry_i),
        .disc_to_i   (disc_to_i),
        .sync_off_i  (sync_off_i),
        .sync_per_i  (sync_per_i),
        .dev_flags_i (dev_flags_i),
        .width_i     (width_i),
        .sense_i     (sense_i),
        .word_o      (gen_w)
    );

    // Pin synchronisers; value taken once stages two and three agree
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            {cf_s1_r, cf_s2_r, cf_s3_r, cf_q_r} <= 32'h0000_0000;
            {tm_s1_r, tm_s2_r, tm_s3_r, tm_q_r} <= 32'h0000_0000;
        end else begin
            {cf_s1_r, cf_s2_r, cf_s3_r} <= {cfig_pin_i, cf_s1_r, cf_s2_r};
            {tm_s1_r, tm_s2_r, tm_s3_r} <= {term_pin_i, tm_s1_r, tm_s2_r};
            if (cf_s2_r == cf_s3_r) begin
                cf_q_r <= cf_s3_r;
            end
            if (tm_s2_r == tm_s3_r) begin
                tm_q_r <= tm_s3_r;
            end
        end
    end

    // Command sequencer: fetch, check, write structure, post status
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_r     <= bic_pkg::BIC_IDLE;
            for (int i = 0; i < 5; i++) begin
                pw_r[i] <= 32'h0000_0000;
            end
            rd_cnt_r <= 3'h0;
            wi_r     <= 7'h00;
            tgt_r    <= 4'h0;
            wrd_r    <= 3'h0;
            code_r   <= `BIC_ST_OK;
            req_r    <= 1'b0;
            we_r     <= 1'b0;
            addr_r   <= 32'h0000_0000;
            wdata_r  <= 32'h0000_0000;
            am_r     <= 8'h00;
            busy_r   <= 1'b0;
            stv_r    <= 1'b0;
            sid_r    <= 32'h0000_0000;
            scode_r  <= `BIC_ST_OK;
        end else begin
            stv_r <= 1'b0;
            case (st_r)
                bic_pkg::BIC_IDLE: begin
                    // Each block, single or from a list, starts here
                    if (start_i) begin
                        req_r    <= 1'b1;
                        we_r     <= 1'b0;
                        addr_r   <= pb_addr_i;
                        am_r     <= pb_am_i;
                        rd_cnt_r <= 3'h0;
                        busy_r   <= 1'b1;
                        st_r     <= bic_pkg::BIC_READ;
                    end
                end
                bic_pkg::BIC_READ: begin
                    // Fetch words 00H to 10H
                    if (mem_ack_i) begin
                        pw_r[rd_cnt_r] <= mem_rdata_i;
                        if (rd_last) begin
                            req_r <= 1'b0;
                            st_r  <= bic_pkg::BIC_CHECK;
                        end else begin
                            rd_cnt_r <= rd_cnt_r + 3'h1;
                            addr_r   <= next_addr(addr_r);
                        end
                    end
                end
                bic_pkg::BIC_CHECK: begin
                    if (cmd_ok) begin
                        req_r   <= 1'b1;
                        we_r    <= 1'b1;
                        addr_r  <= pw_r[`BIC_PW_ADDR];
                        am_r    <= pw_r[`BIC_PW_AM][15:8];
                        wdata_r <= gen_w;
                        wi_r    <= 7'h00;
                        tgt_r   <= 4'h0;
                        wrd_r   <= 3'h0;
                        code_r  <= `BIC_ST_OK;
                        st_r    <= bic_pkg::BIC_WRITE;
                    end else begin
                        // Rejected: no structure, error status only
                        code_r <= id_ok ? `BIC_ST_BADCMD : `BIC_ST_BADID;
                        st_r   <= bic_pkg::BIC_STATUS;
                    end
                end
                bic_pkg::BIC_WRITE: begin
                    if (mem_ack_i) begin
                        if (wi_r == last_w) begin
                            req_r <= 1'b0;
                            we_r  <= 1'b0;
                            st_r  <= bic_pkg::BIC_STATUS;
                        end else begin
                            wi_r    <= n_wi;
                            tgt_r   <= n_tgt;
                            wrd_r   <= n_wrd;
                            addr_r  <= next_addr(addr_r);
                            wdata_r <= gen_w;
                        end
                    end
                end
                bic_pkg::BIC_STATUS: begin
                    // Status only after the last write was acknowledged
                    stv_r   <= 1'b1;
                    sid_r   <= pw_r[`BIC_PW_ID];
                    scode_r <= code_r;
                    busy_r  <= 1'b0;
                    st_r    <= bic_pkg::BIC_IDLE;
                end
                default: begin
                    st_r <= bic_pkg::BIC_IDLE;
                end
            endcase
        end
    end

    // Outputs straight from flops
    assign mem_req_o      = req_r;
    assign mem_we_o       = we_r;
    assign mem_addr_o     = addr_r;
    assign mem_wdata_o    = wdata_r;
    assign mem_am_o       = am_r;
    assign busy_o         = busy_r;
    assign status_valid_o = stv_r;
    assign status_id_o    = sid_r;
    assign status_code_o  = scode_r;

    // Checks on the sequencer
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    am_on_write_a: assert property (mem_req_o && mem_we_o |->
        mem_am_o == pw_r[`BIC_PW_AM][15:8]) else $error("wrong modifier on write");
    start_addr_a: assert property (is_chk && cmd_ok |=>
        mem_req_o && mem_we_o && mem_addr_o == pw_r[`BIC_PW_ADDR])
        else $error("structure not at host address");
    bad_code_a: assert property (is_chk && !code_ok |=>
        st_r == bic_pkg::BIC_STATUS ##1 status_valid_o && status_code_o != `BIC_ST_OK)
        else $error("bad command code not rejected");
    short_walk_a: assert property (st_r == bic_pkg::BIC_WRITE && mem_ack_i &&
        !id_count_format_bit && wi_r == `BIC_LAST8 |=> !mem_req_o ##1 status_valid_o)
        else $error("8 id length wrong");
    hdr_first_a: assert property (is_chk && cmd_ok |=>
        mem_wdata_o == {fw_rel_i, eng_rev_i, throttle_i, sel_flags_i})
        else $error("header word 0 wrong");
    date_word_a: assert property (st_r == bic_pkg::BIC_WRITE && wi_r == 7'h01 |->
        mem_wdata_o == {opt_flags_i, day_i, month_i, year_i}) else $error("date word wrong");
    tgt_zero_a: assert property (st_r == bic_pkg::BIC_WRITE && mem_ack_i &&
        wi_r == 7'h04 |=> tgt_r == 4'h0 && wrd_r == 3'h0 && mem_addr_o == $past(mem_addr_o)
        + 32'h0000_0004) else $error("target walk not from zero");
    limits_word_a: assert property (st_r == bic_pkg::BIC_WRITE && !in_hdr &&
        wrd_r == 3'h0 |-> mem_wdata_o == {sense_cnt_i[tgt_r], retry_i[tgt_r],
        disc_to_i[tgt_r]}) else $error("limits word wrong");
    rsvd_zero_a: assert property (st_r == bic_pkg::BIC_WRITE && wi_r == 7'h04 |->
        mem_wdata_o == 32'h0000_0000) else $error("reserved word not zero");
    status_idle_a: assert property (status_valid_o |->
        !mem_req_o && !busy_o && $past(st_r) == bic_pkg::BIC_STATUS)
        else $error("status while writing");
endmodule // bic_top

// ---- rtl/bic_consts.svh ----
`ifndef BIC_CONSTS_SVH
`define BIC_CONSTS_SVH

// Parameter block word indices (byte offset / 4)
`define BIC_PW_ID       3'h0
`define BIC_PW_AM       3'h1
`define BIC_PW_ADDR     3'h2
`define BIC_PW_CMD      3'h4
`define BIC_PB_LAST     3'h4
// Parameter block field values
`define BIC_ADP_ID      8'hff
`define BIC_CMD_INFO    8'h15
// Options byte sits in bits 23:16 of word 10H; format bit is options bit 1
`define BIC_ID_COUNT_FORMAT_POS 17
// Structure layout in words
`define BIC_HDR_LAST    7'h04
`define BIC_TW_LAST     3'h6
`define BIC_LAST8       7'h3c
`define BIC_LAST16      7'h74
// Header word indices
`define BIC_HW_REV      3'h0
`define BIC_HW_DATE     3'h1
`define BIC_HW_EVEN     3'h2
`define BIC_HW_CFG      3'h3
// Per-target word indices
`define BIC_TW_LIMITS   3'h0
`define BIC_TW_SYNC     3'h1
`define BIC_TW_WIDTH    3'h2
`define BIC_TW_SENSE0   3'h3
// Address step of one word
`define BIC_WSTEP       32'h0000_0004
// Status codes
`define BIC_ST_OK       8'h00
`define BIC_ST_BADID    8'h01
`define BIC_ST_BADCMD   8'h02
// Termination byte: only fuse and power bits are meaningful
`define BIC_TERM_MASK   8'h06
// Adapter base model code, arbitrary value
`define BIC_MODEL       16'h0a5c

`endif

// ---- rtl/bic_pkg.sv ----
package bic_pkg;
    // Command sequencer states
    typedef enum logic [2:0] {
        BIC_IDLE   = 3'b000,
        BIC_READ   = 3'b001,
        BIC_CHECK  = 3'b010,
        BIC_WRITE  = 3'b011,
        BIC_STATUS = 3'b100
    } bic_state_e;
    // Sixteen per-target byte values
    typedef logic [15:0][7:0]        bic_byte16_t;
    // Sixteen per-target halfword values
    typedef logic [15:0][15:0]       bic_half16_t;
    // Sixteen sense bytes for each of sixteen targets
    typedef logic [15:0][15:0][7:0]  bic_sense16_t;
endpackage

// ---- rtl/bic_word_gen.sv ----
`timescale 1ns/1ps
`include "bic_consts.svh"

module bic_word_gen (
    input  wire logic                  hdr_i,        // Header word selected
    input  wire logic [2:0]            hw_i,         // Header word index
    input  wire logic [3:0]            tgt_i,        // Target identifier
    input  wire logic [2:0]            tw_i,         // Word within target block
    input  wire logic [7:0]            fw_rel_i,     // Firmware release level
    input  wire logic [7:0]            eng_rev_i,    // Engineering revision
    input  wire logic [7:0]            throttle_i,   // Bus throttle
    input  wire logic [7:0]            sel_flags_i,  // Select flags
    input  wire logic [7:0]            opt_flags_i,  // Option flags
    input  wire logic [7:0]            day_i,        // Build day
    input  wire logic [7:0]            month_i,      // Build month
    input  wire logic [7:0]            year_i,       // Build year
    input  wire logic [31:0]           even_fw_i,    // Even EPROM firmware number
    input  wire logic [7:0]            cfig_i,       // Synchronised jumper block
    input  wire logic [7:0]            term_i,       // Synchronised termination
    input  wire bic_pkg::bic_byte16_t  sense_cnt_i,  // Sense count per target
    input  wire bic_pkg::bic_byte16_t  retry_i,      // Retry limit per target
    input  wire bic_pkg::bic_half16_t  disc_to_i,    // Disconnect time-out
    input  wire bic_pkg::bic_byte16_t  sync_off_i,   // Synch offset
    input  wire bic_pkg::bic_byte16_t  sync_per_i,   // Synch period
    input  wire bic_pkg::bic_half16_t  dev_flags_i,  // Device flags
    input  wire bic_pkg::bic_byte16_t  width_i,      // Transfer width
    input  wire bic_pkg::bic_sense16_t sense_i,      // Sense bytes
    output logic [31:0]                word_o        // Assembled structure word
);
    // Offset + 0 lands in bits 31:24
    wire [31:0] rev_w  = {fw_rel_i, eng_rev_i, throttle_i, sel_flags_i};
    wire [31:0] date_w = {opt_flags_i, day_i, month_i, year_i};
    wire [31:0] cfg_w  = {`BIC_MODEL, cfig_i, term_i & `BIC_TERM_MASK};
    // Header word select; the reserved word reads zero
    wire [31:0] hdr_w  = (hw_i == `BIC_HW_REV)  ? rev_w  :
                         (hw_i == `BIC_HW_DATE) ? date_w :
                         (hw_i == `BIC_HW_EVEN) ? even_fw_i :
                         (hw_i == `BIC_HW_CFG)  ? cfg_w  : 32'h0000_0000;
    // Sense word group index, 0 to 3
    wire [2:0]  sk3    = tw_i - `BIC_TW_SENSE0;
    wire [1:0]  sk     = sk3[1:0];
    wire [31:0] sns_w  = {sense_i[tgt_i][{sk, 2'b00}], sense_i[tgt_i][{sk, 2'b01}],
                          sense_i[tgt_i][{sk, 2'b10}], sense_i[tgt_i][{sk, 2'b11}]};
    // Per-target word select
    wire [31:0] tgt_w  = (tw_i == `BIC_TW_LIMITS) ?
                             {sense_cnt_i[tgt_i], retry_i[tgt_i], disc_to_i[tgt_i]} :
                         (tw_i == `BIC_TW_SYNC) ?
                             {sync_off_i[tgt_i], sync_per_i[tgt_i], dev_flags_i[tgt_i]} :
                         (tw_i == `BIC_TW_WIDTH) ? {width_i[tgt_i], 24'h00_0000} : sns_w;

    assign word_o = hdr_i ? hdr_w : tgt_w;
endmodule // bic_word_gen

// ---- tb/bic_host_mem.sv ----
`timescale 1ns/1ps

// Host memory: holds parameter blocks and takes the returned structure
module bic_host_mem (
    input  wire logic        mclk_i,  // Clock
    input  wire logic        rst_i,   // Sync reset, high
    input  wire logic        slow_i,  // Two wait cycles per transfer
    input  wire logic        req_i,   // Memory request
    input  wire logic        we_i,    // Write when high
    input  wire logic [31:0] addr_i,  // Byte address
    input  wire logic [31:0] wdata_i, // Write data
    output logic             ack_o,   // One-cycle transfer done
    output logic [31:0]      rdata_o  // Read data, scrambled when idle
);
    logic [31:0] mem [0:1023];        // Word store, byte address bits 11:2
    logic [1:0]  wait_r = 2'h0;       // Wait cycles spent so far

    initial begin
        ack_o = 1'b0;
        rdata_o = 32'h0;
    end

    // One ack per request, never held a second cycle
    always @(posedge mclk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            wait_r <= 2'h0;
        end else if (req_i && !ack_o && (!slow_i || wait_r == 2'h2)) begin
            ack_o <= 1'b1;
            wait_r <= 2'h0;
            rdata_o <= mem[addr_i[11:2]];       // Big-endian word as stored
            if (we_i) begin
                mem[addr_i[11:2]] <= wdata_i;   // Structure lands here
            end
        end else begin
            ack_o <= 1'b0;
            wait_r <= (req_i && !ack_o) ? wait_r + 2'h1 : 2'h0;
            rdata_o <= ~rdata_o;                // Released bus keeps no stale value
        end
    end
endmodule // bic_host_mem

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`include "bic_consts.svh"

// Self-checking bench for the board information command
module tb;
    localparam logic [31:0] PB   = 32'h0000_0100; // Parameter block address
    localparam logic [31:0] DST  = 32'h0000_0400; // Structure address
    localparam logic [31:0] FILL = 32'h5a5a_5a5a; // Untouched memory marker
    logic        mclk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, slow = 1'b0;
    logic [7:0]  exp_am = 8'h0, pam = 8'h09;
    logic [7:0]  fw = 8'h12, er = 8'h34, th = 8'h05, sf = 8'h07, of = 8'h91;
    logic [7:0]  dy = 8'h1c, mo = 8'h06, yr = 8'h61, cf = 8'ha5, tm = 8'hff;
    logic [31:0] ev = 32'h8765_4321, cid = 32'hc0de_0000;
    int          bad_count = 0, n_checks = 0, wr_n = 0, rd_n = 0;
    wire         req, we, ack, busy, st_v;
    wire [31:0]  addr, wdata, rdata, st_id;
    wire [7:0]   am, st_code;
    bic_pkg::bic_byte16_t  sc, rt, so, sp, wd;  // Per-target bytes
    bic_pkg::bic_half16_t  dt, df;              // Per-target halfwords
    bic_pkg::bic_sense16_t sn;                  // Sense bytes

    always #25 mclk_i = ~mclk_i;

    bic_top u_bic_top (
        .mclk_i(mclk_i), .rst_i(rst_i), .start_i(start_i), .pb_addr_i(PB), .pb_am_i(pam),
        .mem_ack_i(ack), .mem_rdata_i(rdata), .fw_rel_i(fw), .eng_rev_i(er),
        .throttle_i(th), .sel_flags_i(sf), .opt_flags_i(of), .day_i(dy), .month_i(mo),
        .year_i(yr), .even_fw_i(ev), .cfig_pin_i(cf), .term_pin_i(tm), .sense_cnt_i(sc),
        .retry_i(rt), .disc_to_i(dt), .sync_off_i(so), .sync_per_i(sp), .dev_flags_i(df),
        .width_i(wd), .sense_i(sn), .mem_req_o(req), .mem_we_o(we), .mem_addr_o(addr),
        .mem_wdata_o(wdata), .mem_am_o(am), .busy_o(busy), .status_valid_o(st_v),
        .status_id_o(st_id), .status_code_o(st_code));

    bic_host_mem u_bic_host_mem (
        .mclk_i(mclk_i), .rst_i(rst_i), .slow_i(slow), .req_i(req), .we_i(we),
        .addr_i(addr), .wdata_i(wdata), .ack_o(ack), .rdata_o(rdata));

    // Expected structure word at word index i
    function automatic logic [31:0] exp_word(input int i);
        int t, w;
        t = (i - 5) / 7;
        w = (i - 5) % 7;
        case (i)
            0: return {fw, er, th, sf};
            1: return {of, dy, mo, yr};
            2: return ev;
            3: return {`BIC_MODEL, cf, tm & `BIC_TERM_MASK};
            4: return 32'h0;
            default: ;
        endcase
        case (w)
            0: return {sc[t], rt[t], dt[t]};
            1: return {so[t], sp[t], df[t]};
            2: return {wd[t], 24'h0};
            default: return {sn[t][4*w-12], sn[t][4*w-11], sn[t][4*w-10], sn[t][4*w-9]};
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Each completing transfer: structure writes use host modifier and ascend,
    // parameter fetches use the fetch modifier and walk the block in order
    always @(negedge mclk_i) begin
        if (!rst_i && req && ack && we) begin
            chk(32'(am), 32'(exp_am));
            chk(addr, DST + 32'(4 * wr_n));
            wr_n = wr_n + 1;
        end else if (!rst_i && req && ack) begin
            chk(32'(am), 32'(pam));
            chk(addr, PB + 32'(4 * rd_n));
            rd_n = rd_n + 1;
        end
    end

    // Issue one parameter block, await status, check memory image
    task automatic run_cmd(input logic [7:0] a_m, input logic [7:0] adp, input logic [7:0] cmd,
                           input logic [7:0] opt, input logic sl, input logic [7:0] code,
                           input int n_wr);
        int k;
        exp_am = a_m;
        slow = sl;
        wr_n = 0;
        rd_n = 0;
        cid = cid + 32'h0000_0101;
        for (k = 0; k < 128; k++) u_bic_host_mem.mem[DST[11:2] + k] = FILL;
        u_bic_host_mem.mem[PB[11:2]] = cid;
        u_bic_host_mem.mem[PB[11:2] + 1] = {16'h0, a_m, adp};
        u_bic_host_mem.mem[PB[11:2] + 2] = DST;
        u_bic_host_mem.mem[PB[11:2] + 3] = 32'h0;
        u_bic_host_mem.mem[PB[11:2] + 4] = {cmd, opt, 16'h0};
        @(negedge mclk_i) start_i = 1'b1;
        @(negedge mclk_i) chk(32'(busy), 32'h1);
        // Start held over a second edge: refused while busy
        @(negedge mclk_i) start_i = 1'b0;
        for (k = 0; k < 3000; k++) begin
            if (st_v === 1'b1) break;
            @(negedge mclk_i);
        end
        chk(32'(st_v), 32'h1);
        chk(32'(busy), 32'h0);
        chk(32'(rd_n), 32'h5);
        chk(st_id, cid);
        chk(32'(st_code), 32'(code));
        chk(32'(wr_n), 32'(n_wr));
        for (k = 0; k < n_wr; k++) chk(u_bic_host_mem.mem[DST[11:2] + k], exp_word(k));
        chk(u_bic_host_mem.mem[DST[11:2] + n_wr], FILL);
        @(negedge mclk_i);
    endtask

    // Eight targets despite every other options bit set
    task automatic t_ids8;
        run_cmd(8'h3d, 8'hff, 8'h15, 8'hfd, 1'b0, `BIC_ST_OK, 61);
    endtask
    // Sixteen targets with a slow memory
    task automatic t_ids16;
        run_cmd(8'h0d, 8'hff, 8'h15, 8'h02, 1'b1, `BIC_ST_OK, 117);
    endtask
    // Wrong adapter byte: no writes
    task automatic t_bad_id;
        run_cmd(8'h3d, 8'h7f, 8'h15, 8'h02, 1'b0, `BIC_ST_BADID, 0);
    endtask
    // Wrong command code: no writes
    task automatic t_bad_cmd;
        run_cmd(8'h3d, 8'hff, 8'h14, 8'h02, 1'b1, `BIC_ST_BADCMD, 0);
    endtask

    // Watchdog on a hung run
    initial begin
        #2000000;
        bad_count++;
        end_of_test;
    end

    // Main sequence
    initial begin
        for (int t = 0; t < 16; t++) begin
            sc[t] = 8'h10 + 8'(t);
            rt[t] = 8'h20 + 8'(t);
            dt[t] = 16'h3000 + 16'(t);
            so[t] = 8'h40 + 8'(t);
            sp[t] = 8'h50 + 8'(t);
            df[t] = 16'h6000 + 16'(t);
            wd[t] = 8'h70 + 8'(t);
            for (int b = 0; b < 16; b++) sn[t][b] = {4'(t), 4'(b)};
        end
        repeat (6) @(negedge mclk_i);
        rst_i = 1'b0;
        t_ids8;
        t_ids16;
        t_bad_id;
        t_bad_cmd;
        t_ids8;
        end_of_test;
    end
endmodule // tb
